// [rtl/dmr_pkg.sv]
package dmr_pkg;
   // register bus geometry
   localparam int REG_W  = 32;
   localparam int ADDR_W = 8;
   // register offsets, byte addresses on word boundaries
   localparam logic [7:0] OFS_RD_CTRL  = 8'h00;
   localparam logic [7:0] OFS_RD_STS   = 8'h04;
   localparam logic [7:0] OFS_RD_CUR   = 8'h08;
   localparam logic [7:0] OFS_RD_TAIL  = 8'h10;
   localparam logic [7:0] OFS_RD_SRC   = 8'h18;
   localparam logic [7:0] OFS_RD_LEN   = 8'h28;
   localparam logic [7:0] OFS_DESCRIPTOR_USER_CACHE_CONTROL   = 8'h2c;
   localparam logic [7:0] OFS_WR_CTRL  = 8'h30;
   localparam logic [7:0] OFS_WR_STS   = 8'h34;
   localparam logic [7:0] OFS_WR_CUR   = 8'h38;
   localparam logic [7:0] OFS_WR_TAIL  = 8'h40;
   localparam logic [7:0] OFS_WR_DST   = 8'h48;
   localparam logic [7:0] OFS_WR_LEN   = 8'h58;
   localparam logic [7:0] OFS_IRQ_STS  = 8'h60;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h64;
   // control and status field positions
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_ONE_BIT   = 1;
   localparam int STS_HALTED_BIT = 0;
   localparam int STS_IDLE_BIT   = 1;
   // interrupt event bits
   localparam int IRQ_W          = 3;
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_SLVERR_BIT = 1;
   localparam int IRQ_DECERR_BIT = 2;
   // write response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_EXOKAY = 2'h1;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // fixed write address attributes
   localparam logic [1:0] BURST_INCR  = 2'h1;
   localparam logic [3:0] AW_CACHE    = 4'h3;
   localparam logic [2:0] AW_PROT     = 3'h2;
   localparam int         BYTE_BITS   = 8;
   localparam int         WORD_BYTES  = 4;
   // one register access from software
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0]  wdata;
      logic              wr;
      logic              rd;
   } dmr_reg_req_t;
   // descriptor write sequencer states
   typedef enum logic [3:0] {
      DMR_IDLE = 4'h1,
      DMR_ADDR = 4'h2,
      DMR_DATA = 4'h4,
      DMR_RESP = 4'h8
   } dmr_state_t;
endpackage

// [rtl/dmr_register_map.sv]
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module dmr_register_map
#(
   parameter bit DESC_MODE_EN    = 1'b1, // descriptor_mode_enable_param
   parameter bit MULTICHANNEL_EN = 1'b0, // builds the 2ch register
   parameter int DESC_DATA_W     = 32,   // descriptor_port_data_width_param
   parameter int DESC_BEATS      = 4     // beats per descriptor write
)
(
   input  wire logic                       sys_clk,
   input  wire logic                       reset_n,
   input  wire dmr_pkg::dmr_reg_req_t      reg_req,
   output logic [dmr_pkg::REG_W-1:0]       reg_rdata,
   output logic                            irq,
   output logic [31:0]                     descriptor_write_address,
   output logic [7:0]                      descriptor_write_length,
   output logic [2:0]                      descriptor_write_size,
   output logic [1:0]                      descriptor_write_burst,
   output logic [3:0]                      descriptor_write_cache,
   output logic [2:0]                      descriptor_write_prot,
   output logic                            descriptor_address_valid,
   input  wire logic                       descriptor_address_ready,
   output logic [DESC_DATA_W-1:0]          descriptor_write_data,
   output logic [DESC_DATA_W/8-1:0]        descriptor_write_strobe,
   output logic                            descriptor_write_last,
   output logic                            descriptor_write_valid,
   input  wire logic                       descriptor_write_ready,
   input  wire logic [1:0]                 descriptor_write_response,
   input  wire logic                       descriptor_response_valid,
   output logic                            descriptor_response_ready
);
   import dmr_pkg::*;

   localparam int         STRB_W    = DESC_DATA_W / BYTE_BITS;
   localparam logic [7:0] BURST_LEN = 8'(DESC_BEATS - 1);
   localparam logic [2:0] BEAT_SIZE = 3'($clog2(STRB_W));

   // whole state of the block in one vector
   typedef struct packed {
      logic                   rd_run;    // read channel run bit
      logic                   wr_run;    // write channel run bit
      logic [REG_W-1:0]       rd_cur;    // read current descriptor
      logic [REG_W-1:0]       rd_tail;   // read tail descriptor
      logic [REG_W-1:0]       rd_src;    // simple mode source address
      logic [REG_W-1:0]       rd_len;    // simple mode read length
      logic [REG_W-1:0]       descriptor_user_cache_control;    // user and cache control
      logic [REG_W-1:0]       wr_cur;    // write current descriptor
      logic [REG_W-1:0]       wr_tail;   // write tail descriptor
      logic [REG_W-1:0]       wr_dst;    // simple mode destination
      logic [REG_W-1:0]       wr_len;    // simple mode buffer length
      logic [IRQ_W-1:0]       irq_sts;   // sticky events
      logic [IRQ_W-1:0]       irq_mask;  // event enables
      logic [REG_W-1:0]       rdata;     // read data, one cycle late
      dmr_state_t             fsm;       // descriptor write sequencer
      logic                   chan;      // 0 read channel, 1 write channel
      logic [7:0]             beat;      // beat index in burst
      logic [31:0]            awaddr;    // burst start address
      logic                   awvalid;   // address valid
      logic [DESC_DATA_W-1:0] wdata;     // beat data
      logic [STRB_W-1:0]      wstrb;     // byte strobes
      logic                   wvalid;    // data valid
      logic                   wlast;     // final beat marker
      logic                   bready;    // response ready
      logic                   irq;       // interrupt level
   } dmr_vec_t;

   dmr_vec_t         s_q;   // registered state
   dmr_vec_t         s_d;   // next state
   logic [IRQ_W-1:0] clr;   // software clear this cycle
   logic [IRQ_W-1:0] set;   // hardware events this cycle
   logic             go;    // burst request from a tail write
   logic             go_ch; // channel of that request

   // control word: bit 1 always reads one
   function automatic logic [REG_W-1:0] ctrl_word(input logic run);
      logic [REG_W-1:0] v;
      v = '0;
      v[CTRL_RUN_BIT] = run;
      v[CTRL_ONE_BIT] = 1'b1;
      return v;
   endfunction

   // status word: halted mirrors a stopped channel
   function automatic logic [REG_W-1:0] sts_word(input logic run, input logic idle);
      logic [REG_W-1:0] v;
      v = '0;
      v[STS_HALTED_BIT] = ~run;
      v[STS_IDLE_BIT]   = idle;
      return v;
   endfunction

   // read mux; anything not decoded in this build reads zero
   function automatic logic [REG_W-1:0] reg_read(input logic [ADDR_W-1:0] a,
                                                 input dmr_vec_t s);
      logic [REG_W-1:0] v;
      logic             rd_idle;
      logic             wr_idle;
      v       = '0;
      rd_idle = (s.fsm == DMR_IDLE) || s.chan;
      wr_idle = (s.fsm == DMR_IDLE) || !s.chan;
      case (a)
         OFS_RD_CTRL:  v = ctrl_word(s.rd_run);
         OFS_RD_STS:   v = sts_word(s.rd_run, rd_idle);
         OFS_WR_CTRL:  v = ctrl_word(s.wr_run);
         OFS_WR_STS:   v = sts_word(s.wr_run, wr_idle);
         OFS_RD_CUR:   v = DESC_MODE_EN ? s.rd_cur : '0;
         OFS_RD_TAIL:  v = DESC_MODE_EN ? s.rd_tail : '0;
         OFS_WR_CUR:   v = DESC_MODE_EN ? s.wr_cur : '0;
         OFS_WR_TAIL:  v = DESC_MODE_EN ? s.wr_tail : '0;
         OFS_RD_SRC:   v = DESC_MODE_EN ? '0 : s.rd_src;
         OFS_RD_LEN:   v = DESC_MODE_EN ? '0 : s.rd_len;
         OFS_WR_DST:   v = DESC_MODE_EN ? '0 : s.wr_dst;
         OFS_WR_LEN:   v = DESC_MODE_EN ? '0 : s.wr_len;
         OFS_DESCRIPTOR_USER_CACHE_CONTROL:   v = (DESC_MODE_EN && MULTICHANNEL_EN) ? s.descriptor_user_cache_control : '0;
         OFS_IRQ_STS:  v = REG_W'(s.irq_sts);
         OFS_IRQ_MASK: v = REG_W'(s.irq_mask);
         default:      v = '0;
      endcase
      return v;
   endfunction

   // beat payload: tail pointer plus beat index, copied to every word lane
   function automatic logic [DESC_DATA_W-1:0] desc_word(input logic [REG_W-1:0] tail,
                                                        input logic [7:0]       beat);
      return {(DESC_DATA_W / REG_W){tail + REG_W'(beat)}};
   endfunction

   // next-state logic: register writes, sequencer, events
   always_comb
   begin
      s_d      = s_q;
      s_d.rdata = '0;
      clr      = '0;
      set      = '0;
      go       = 1'b0;
      go_ch    = 1'b0;
      // read data stands only in the cycle after the strobe
      if (reg_req.rd)
      begin
         s_d.rdata = reg_read(reg_req.addr, s_q);
      end
      // software writes; full words, so no lane merging is needed
      if (reg_req.wr)
      begin
         case (reg_req.addr)
            OFS_RD_CTRL:  s_d.rd_run = reg_req.wdata[CTRL_RUN_BIT];
            OFS_WR_CTRL:  s_d.wr_run = reg_req.wdata[CTRL_RUN_BIT];
            OFS_RD_CUR:   if (DESC_MODE_EN) s_d.rd_cur = reg_req.wdata;
            OFS_WR_CUR:   if (DESC_MODE_EN) s_d.wr_cur = reg_req.wdata;
            OFS_RD_TAIL:
            begin
               if (DESC_MODE_EN)
               begin
                  s_d.rd_tail = reg_req.wdata;
                  go          = s_q.rd_run;
                  go_ch       = 1'b0;
               end
            end
            OFS_WR_TAIL:
            begin
               if (DESC_MODE_EN)
               begin
                  s_d.wr_tail = reg_req.wdata;
                  go          = s_q.wr_run;
                  go_ch       = 1'b1;
               end
            end
            OFS_RD_SRC:   if (!DESC_MODE_EN) s_d.rd_src = reg_req.wdata;
            OFS_RD_LEN:   if (!DESC_MODE_EN) s_d.rd_len = reg_req.wdata;
            OFS_WR_DST:   if (!DESC_MODE_EN) s_d.wr_dst = reg_req.wdata;
            OFS_WR_LEN:   if (!DESC_MODE_EN) s_d.wr_len = reg_req.wdata;
            OFS_DESCRIPTOR_USER_CACHE_CONTROL:   if (DESC_MODE_EN && MULTICHANNEL_EN) s_d.descriptor_user_cache_control = reg_req.wdata;
            OFS_IRQ_STS:  clr = reg_req.wdata[IRQ_W-1:0];
            OFS_IRQ_MASK: s_d.irq_mask = reg_req.wdata[IRQ_W-1:0];
            default:      ;
         endcase
      end
      // descriptor write sequencer; a tail write while busy only stores the pointer
      case (s_q.fsm)
         DMR_IDLE:
         begin
            if (go)
            begin
               s_d.chan    = go_ch;
               s_d.awaddr  = go_ch ? s_q.wr_cur : s_q.rd_cur;
               s_d.awvalid = 1'b1;
               s_d.beat    = '0;
               s_d.fsm     = DMR_ADDR;
            end
         end
         DMR_ADDR:
         begin
            if (descriptor_address_ready)
            begin
               s_d.awvalid = 1'b0;
               s_d.wvalid  = 1'b1;
               s_d.wdata   = desc_word(s_q.chan ? s_q.wr_tail : s_q.rd_tail, 8'h00);
               s_d.wlast   = (BURST_LEN == 8'h00);
               s_d.fsm     = DMR_DATA;
            end
         end
         DMR_DATA:
         begin
            // beat held until the slave takes it
            if (descriptor_write_ready)
            begin
               if (s_q.wlast)
               begin
                  s_d.wvalid = 1'b0;
                  s_d.wlast  = 1'b0;
                  s_d.bready = 1'b1;
                  s_d.fsm    = DMR_RESP;
               end
               else
               begin
                  s_d.beat  = s_q.beat + 8'h01;
                  s_d.wdata = desc_word(s_q.chan ? s_q.wr_tail : s_q.rd_tail, s_d.beat);
                  s_d.wlast = (s_d.beat == BURST_LEN);
               end
            end
         end
         DMR_RESP:
         begin
            // the slave's code is trusted only with its valid
            if (descriptor_response_valid)
            begin
               s_d.bready = 1'b0;
               s_d.fsm    = DMR_IDLE;
               case (descriptor_write_response)
                  RESP_OKAY:
                  begin
                     set[IRQ_DONE_BIT] = 1'b1;
                     if (s_q.chan) s_d.wr_cur = s_q.wr_tail;
                     else          s_d.rd_cur = s_q.rd_tail;
                  end
                  RESP_DECERR:
                  begin
                     set[IRQ_DECERR_BIT] = 1'b1;
                     if (s_q.chan) s_d.wr_run = 1'b0;
                     else          s_d.rd_run = 1'b0;
                  end
                  default:
                  begin
                     // slave error; exclusive okay is unsupported and counts the same
                     set[IRQ_SLVERR_BIT] = 1'b1;
                     if (s_q.chan) s_d.wr_run = 1'b0;
                     else          s_d.rd_run = 1'b0;
                  end
               endcase
            end
         end
         default:
         begin
            s_d.fsm = DMR_IDLE;
         end
      endcase
      // set beats clear so no event is lost
      s_d.irq_sts = (s_q.irq_sts & ~clr) | set;
      s_d.irq     = |(s_d.irq_sts & s_d.irq_mask);
      s_d.wstrb   = '1;
   end

   // state register, synchronous reset
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         s_q       <= '0;
         s_q.fsm   <= DMR_IDLE;
         s_q.wstrb <= '1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state vector
   assign reg_rdata                 = s_q.rdata;
   assign irq                       = s_q.irq;
   assign descriptor_write_address  = s_q.awaddr;
   assign descriptor_address_valid  = s_q.awvalid;
   assign descriptor_write_data     = s_q.wdata;
   assign descriptor_write_strobe   = s_q.wstrb;
   assign descriptor_write_last     = s_q.wlast;
   assign descriptor_write_valid    = s_q.wvalid;
   assign descriptor_response_ready = s_q.bready;
   // fixed attributes; no state behind them
   assign descriptor_write_length   = BURST_LEN;
   assign descriptor_write_size     = BEAT_SIZE;
   assign descriptor_write_burst    = BURST_INCR;
   assign descriptor_write_cache    = AW_CACHE;
   assign descriptor_write_prot     = AW_PROT;

   // checks on the driven side
   default clocking dmr_cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_strobe_all_ones: assert property (s_q.wvalid |-> &descriptor_write_strobe)
      else $error("strobe not all ones on a beat");
   a_last_ends_burst: assert property (s_q.wvalid && s_q.wlast && descriptor_write_ready
                                       |=> !s_q.wvalid && s_q.bready)
      else $error("last beat did not end the burst");
   a_last_on_final: assert property (s_q.wvalid |-> (s_q.wlast == (s_q.beat == BURST_LEN)))
      else $error("last flag on wrong beat");
   a_slverr_event: assert property (s_q.bready && descriptor_response_valid
                                    && descriptor_write_response == RESP_SLVERR
                                    |=> s_q.irq_sts[IRQ_SLVERR_BIT] && !s_q.bready)
      else $error("slave error not recorded");
   a_decerr_event: assert property (s_q.bready && descriptor_response_valid
                                    && descriptor_write_response == RESP_DECERR
                                    |=> s_q.irq_sts[IRQ_DECERR_BIT])
      else $error("decode error not recorded");
   a_bready_reset: assert property (disable iff (1'b0) !reset_n |=> !descriptor_response_ready)
      else $error("response ready high after reset");
   a_wvalid_reset: assert property (disable iff (1'b0) !reset_n |=> !descriptor_write_valid)
      else $error("write valid high after reset");
   a_wvalid_holds: assert property (s_q.wvalid && !descriptor_write_ready
                                    |=> s_q.wvalid && $stable(s_q.wdata))
      else $error("beat dropped before ready");
   a_reserved_zero: assert property (reg_req.rd && reg_req.addr == 8'h0c |=> reg_rdata == '0)
      else $error("reserved offset read not zero");
   a_burst_incr: assert property (s_q.awvalid |-> descriptor_write_burst == BURST_INCR
                                  && descriptor_write_cache == AW_CACHE
                                  && descriptor_write_prot == AW_PROT)
      else $error("write address attributes wrong");
   a_irq_level: assert property (irq == |(s_q.irq_sts & s_q.irq_mask))
      else $error("interrupt level wrong");
   // ready must only be offered while a response is owed
   a_ready_waits: assert property (descriptor_response_ready |-> s_q.fsm == DMR_RESP)
      else $error("response ready outside response wait");
   // data channel opens only after the address handshake
   a_no_overlap: assert property (!(s_q.awvalid && s_q.wvalid))
      else $error("address and data valid together");
   a_okay_event: assert property (s_q.bready && descriptor_response_valid
                                  && descriptor_write_response == RESP_OKAY
                                  |=> s_q.irq_sts[IRQ_DONE_BIT] && !s_q.bready)
      else $error("completion not recorded");
   // strobes stand all ones even while held in reset
   a_strobe_reset: assert property (disable iff (1'b0) !reset_n |=> &descriptor_write_strobe)
      else $error("strobe not all ones after reset");

   c_okay_done: cover property (s_q.bready && descriptor_response_valid
                                && descriptor_write_response == RESP_OKAY);
   c_slverr: cover property (s_q.bready && descriptor_response_valid
                             && descriptor_write_response == RESP_SLVERR);
   c_backpressure: cover property ((s_q.wvalid && !descriptor_write_ready) [*2]);
   c_clear_collide: cover property (|(set & clr));
endmodule
`default_nettype wire

// [sim/dmr_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// memory side target for descriptor write bursts
module dmr_mem_model
#(
   parameter int BEATS = 4
)
(
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        slow,
   input  wire logic [1:0]  resp_code,
   input  wire logic [31:0] aw_addr,
   input  wire logic        aw_valid,
   output logic             aw_ready,
   input  wire logic [31:0] w_data,
   input  wire logic [3:0]  w_strb,
   input  wire logic        w_last,
   input  wire logic        w_valid,
   output logic             w_ready,
   output logic [1:0]       b_resp,
   output logic             b_valid,
   input  wire logic        b_ready,
   output logic [31:0]      addr_seen,
   output logic [31:0]      data_first,
   output logic [31:0]      data_final,
   output logic [7:0]       beat_cnt,
   output logic             fault
);
   logic pend; // response owed after last beat
   // readies, beat capture and response in one process
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         aw_ready <= 1'b0;
         w_ready <= 1'b0;
         b_valid <= 1'b0;
         b_resp <= 2'h0;
         pend <= 1'b0;
         fault <= 1'b0;
         beat_cnt <= 8'h0;
      end
      else
      begin
         // slow mode stalls at random, as a busy memory would
         aw_ready <= !slow | 1'($urandom);
         w_ready <= !slow | 1'($urandom);
         if (aw_valid && aw_ready)
         begin
            addr_seen <= aw_addr;
            beat_cnt <= 8'h0;
         end
         if (w_valid && w_ready)
         begin
            beat_cnt <= beat_cnt + 8'h1;
            if (beat_cnt == 8'h0)
               data_first <= w_data;
            data_final <= w_data;
            // sticky: strobe lanes or last flag wrong on any beat
            if (w_strb != 4'hf || w_last != (beat_cnt == 8'(BEATS-1)))
               fault <= 1'b1;
            pend <= w_last;
         end
         // released code turns to its inverse, never left readable
         if (b_valid && b_ready)
         begin
            b_valid <= 1'b0;
            b_resp <= ~b_resp;
         end
         else if (pend && !b_valid && (!slow | 1'($urandom)))
         begin
            b_valid <= 1'b1;
            b_resp <= resp_code;
            pend <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// [sim/dma_register_map_sg_write_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module dma_register_map_sg_write_port_test;
   import dmr_pkg::*;
   localparam int BEATS = 4;
   logic         sys_clk = 1'b0;
   logic         reset_n = 1'b0;
   dmr_reg_req_t reg_req = '0;
   logic [31:0]  rdata, rdata_s, awaddr, wdata, addr_seen, data_first, data_final;
   logic [7:0]   awlen, beat_cnt;
   logic [2:0]   awsize, awprot;
   logic [1:0]   awburst, bresp;
   logic [3:0]   awcache, wstrb;
   logic         irq, awvalid, awready, wlast, wvalid, wready, bvalid, bready, fault;
   logic         slow = 1'b0;
   logic [1:0]   resp_code = 2'h0;
   int           err_total = 0;
   int           checks_done = 0;
   int           cycles = 0;
   // 100 mhz
   always #5 sys_clk = ~sys_clk;
   // descriptor build facing the model
   dmr_register_map #(.DESC_BEATS(BEATS)) uut (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(rdata),
      .irq(irq), .descriptor_write_address(awaddr), .descriptor_write_length(awlen),
      .descriptor_write_size(awsize), .descriptor_write_burst(awburst),
      .descriptor_write_cache(awcache), .descriptor_write_prot(awprot),
      .descriptor_address_valid(awvalid), .descriptor_address_ready(awready),
      .descriptor_write_data(wdata), .descriptor_write_strobe(wstrb),
      .descriptor_write_last(wlast), .descriptor_write_valid(wvalid),
      .descriptor_write_ready(wready), .descriptor_write_response(bresp),
      .descriptor_response_valid(bvalid), .descriptor_response_ready(bready));
   // simple build sharing the register bus; its far side stays quiet
   dmr_register_map #(.DESC_MODE_EN(1'b0)) uut_s (
      .sys_clk(sys_clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(rdata_s),
      .irq(), .descriptor_write_address(), .descriptor_write_length(),
      .descriptor_write_size(), .descriptor_write_burst(), .descriptor_write_cache(),
      .descriptor_write_prot(), .descriptor_address_valid(),
      .descriptor_address_ready(1'b0), .descriptor_write_data(),
      .descriptor_write_strobe(), .descriptor_write_last(), .descriptor_write_valid(),
      .descriptor_write_ready(1'b0), .descriptor_write_response(2'h0),
      .descriptor_response_valid(1'b0), .descriptor_response_ready());
   dmr_mem_model #(.BEATS(BEATS)) mem (
      .sys_clk(sys_clk), .reset_n(reset_n), .slow(slow), .resp_code(resp_code),
      .aw_addr(awaddr), .aw_valid(awvalid), .aw_ready(awready), .w_data(wdata),
      .w_strb(wstrb), .w_last(wlast), .w_valid(wvalid), .w_ready(wready),
      .b_resp(bresp), .b_valid(bvalid), .b_ready(bready), .addr_seen(addr_seen),
      .data_first(data_first), .data_final(data_final), .beat_cnt(beat_cnt),
      .fault(fault));
   // verdict and end of run
   task automatic results();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles needed
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         $display("wrong value at %0t: timeout", $time);
         results();
      end
   end
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: word %h not %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: flag %b not %b", $time, got, exp);
      end
   endtask
   // one write cycle; taken at the second edge
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge sys_clk);
      reg_req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d, output logic [31:0] ds);
      @(posedge sys_clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge sys_clk);
      reg_req.rd <= 1'b0;
      #1;
      d = rdata;
      ds = rdata_s;
   endtask
   // decoded words per build; all else reads zero
   function automatic logic [31:0] exp_rw(input bit sg, input logic [7:0] a, input logic [31:0] w);
      if (sg)
         return (a inside {8'h08, 8'h10, 8'h38, 8'h40}) ? w : 32'h0;
      return (a inside {8'h18, 8'h28, 8'h48, 8'h58}) ? w : 32'h0;
   endfunction
   // event bit raised by a response code; exclusive-okay counts as slave error
   function automatic logic [31:0] exp_evt(input logic [1:0] c);
      return (c == 2'h0) ? 32'h1 : (c == 2'h3) ? 32'h4 : 32'h2;
   endfunction
   initial
   begin
      logic [31:0] v, vs, tail, ign;
      logic [7:0]  a, base;
      logic [1:0]  codes [4];
      logic [31:0] cur [2];
      codes = '{2'h0, 2'h2, 2'h3, 2'h1};
      v = $urandom(88043);
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      // control reads 2, status halted and idle, in both builds
      for (int k = 0; k < 4; k++)
      begin
         a = (k[0] ? 8'h30 : 8'h00) + (k[1] ? 8'h04 : 8'h00);
         reg_rd(a, v, vs);
         chk_word(v, k[1] ? 32'h3 : 32'h2);
         chk_word(vs, k[1] ? 32'h3 : 32'h2);
      end
      chk_flag(bready, 1'b0);
      chk_flag(wvalid, 1'b0);
      chk_word({28'h0, wstrb}, 32'hf);
      chk_word({23'h0, awburst, awcache, awprot}, {23'h0, 2'h1, 4'h3, 3'h2});
      chk_word({21'h0, awlen, awsize}, {21'h0, 8'(BEATS-1), 3'h2});
      // walk the window with random words, both builds at once
      for (int o = 8; o <= 8'h5c; o += 4)
      begin
         a = 8'(o);
         if (a == 8'h30 || a == 8'h34)
            continue;
         tail = $urandom;
         if (a == 8'h08 || a == 8'h38)
            cur[a[4]] = tail;
         reg_wr(a, tail);
         reg_rd(a, v, vs);
         chk_word(v, exp_rw(1'b1, a, tail));
         chk_word(vs, exp_rw(1'b0, a, tail));
      end
      // bursts on both channels, every response code, prompt then slow
      for (int k = 0; k < 4; k++)
      begin
         base = k[0] ? 8'h30 : 8'h00;
         slow <= k[1];
         resp_code <= codes[k];
         tail = $urandom;
         reg_wr(base, 32'h1);
         reg_wr(base + 8'h10, tail);
         v = 32'h0;
         for (int n = 0; n < 60 && v == 32'h0; n++)
            reg_rd(8'h60, v, vs);
         chk_word(v, exp_evt(codes[k]));
         chk_flag(irq, 1'b0);
         chk_flag(bready, 1'b0);
         chk_word(addr_seen, cur[k[0]]);
         chk_word({24'h0, beat_cnt}, 32'(BEATS));
         chk_word(data_first, tail);
         chk_word(data_final, tail + 32'(BEATS-1));
         chk_flag(fault, 1'b0);
         reg_rd(base, vs, ign);
         chk_word(vs, (codes[k] == 2'h0) ? 32'h3 : 32'h2);
         if (codes[k] == 2'h0)
            cur[k[0]] = tail;
         reg_rd(base + 8'h08, vs, ign);
         chk_word(vs, cur[k[0]]);
         // unmask, then clear by writing the ones back
         reg_wr(8'h64, 32'h7);
         @(posedge sys_clk);
         #1;
         chk_flag(irq, 1'b1);
         reg_wr(8'h60, v);
         reg_rd(8'h60, v, vs);
         chk_word(v, 32'h0);
         chk_flag(irq, 1'b0);
         reg_wr(8'h64, 32'h0);
      end
      results();
   end
endmodule
`default_nettype wire
